// [rx_sync_edge.sv]
// Purpose: bring the receive pin into the clock domain, report edges
// Assumes: pin idles high between characters
// Notes:   level changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module rx_sync_edge (
  input  wire logic clk,   // system clock
  input  wire logic rst_n, // synchronous reset, active low
  input  wire logic ce,    // clock enable, freezes state
  input  wire logic pin,   // raw receive pin
  output logic      level, // filtered pin level
  output logic      rise,  // one-cycle pulse on low to high
  output logic      fall   // one-cycle pulse on high to low
);

  logic s1_r, s2_r, s3_r;      // synchroniser chain
  logic lvl_r, lvl_nxt;        // accepted level
  logic rise_r, rise_nxt;      // registered edge pulses
  logic fall_r, fall_nxt;

  // ----------------------------------------------------------------
  // next level: only a stable pair of late stages moves it
  // ----------------------------------------------------------------
  always_comb
  begin
    lvl_nxt  = (s2_r == s3_r) ? s3_r : lvl_r;
    rise_nxt = lvl_nxt & ~lvl_r;
    fall_nxt = ~lvl_nxt & lvl_r;
  end

  // ----------------------------------------------------------------
  // registers; s1 feeds s2 and nothing else
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      s3_r   <= 1'b1;
      lvl_r  <= 1'b1;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end
    else if (ce)
    begin
      s1_r   <= pin;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  // pulses only count while the clock is enabled
  assign level = lvl_r;
  assign rise  = rise_r & ce;
  assign fall  = fall_r & ce;

endmodule : rx_sync_edge

`default_nettype wire

// [rx_tx_model.sv]
// Purpose: far-end serial transmitter driving the receive pin
// Assumes: tasks are entered just after a rising clock edge
// Notes:   line idles high and is driven at all times
`timescale 1ns/1ps
`default_nettype none

module rx_tx_model (
  input  wire logic clk,  // system clock
  output var logic  line  // serial line towards the block
);
  // ----------------------------------------------------------------
  // line control
  // ----------------------------------------------------------------
  initial line = 1'b1; // idle level between frames

  // static level, used for bare edge tests
  task automatic drive(input logic v);
    line <= v;
  endtask : drive

  // one frame, lsb first, p clocks per bit; p may be short or long
  task automatic send(input logic [7:0] d, input int p);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line <= f[i];
      repeat (p) @(posedge clk);
    end
  endtask : send
endmodule : rx_tx_model

`default_nettype wire

// [uart_baud_wake_autobaud_ctrl.sv]
// Purpose: baud control bits: generator width, wake monitor, autobaud
// Assumes: apb slave, zero wait states, receive pin idles high
// Notes:   autobaud parks the generator while it measures
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - width bit selects 16-bit or 8-bit generator
// - bit 2 reads zero, writes ignored
// - async wake: falling rx edge raises interrupt
// - following rising edge clears wake enable
// - wake disabled: no monitoring, no clearing
// - synchronous mode ignores wake enable
// - autobaud measures next 55h sync character
// - autobaud enable clears itself when done
module uart_baud_wake_autobaud_ctrl #(
  parameter int MEAS_W = 19 // measurement counter width
) (
  input  wire logic        clk,     // system clock, 50 MHz
  input  wire logic        rst_n,   // synchronous reset, active low
  input  wire logic        ce,      // clock enable, freezes all state
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb access phase
  input  wire logic        pwrite,  // apb direction
  input  wire logic [7:0]  paddr,   // apb byte address
  input  wire logic [31:0] pwdata,  // apb write data
  output logic [31:0]      prdata,  // apb read data
  output logic             pready,  // apb ready
  output logic             pslverr, // apb error on unmapped address
  input  wire logic        rx_pin,  // receive pin from far transmitter
  output logic             baud_tick, // one pulse per generator period
  output logic             irq      // level interrupt
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [uart_bwa_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;   // baud_control
  logic                            sync_r, sync_nxt;   // mode select
  logic [15:0]                     div_r, div_nxt;     // divisor
  logic [uart_bwa_pkg::EV_W-1:0]   stat_r, stat_nxt;   // sticky events
  logic [uart_bwa_pkg::EV_W-1:0]   mask_r, mask_nxt;   // event mask
  logic                            armed_r, armed_nxt; // wake edge seen
  uart_bwa_pkg::abd_state_t        abd_r, abd_nxt;     // autobaud state
  logic [2:0]                      falls_r, falls_nxt; // falling edges
  logic [MEAS_W-1:0]               meas_r, meas_nxt;   // clocks measured
  logic [15:0]                     gen_r, gen_nxt;     // generator count
  logic                            tick_r, tick_nxt;   // generator tick
  logic [31:0]                     rd_r, rd_nxt;       // read data
  logic                            err_r, err_nxt;     // read/write error
  logic                            rx_lvl, rx_rise, rx_fall;
  logic                            setup, access, wr;
  logic [15:0]                     reload;             // masked divisor
  logic [15:0]                     meas_div;           // measured divisor
  logic [uart_bwa_pkg::EV_W-1:0]   ev_set;             // events this cycle

  // ----------------------------------------------------------------
  // receive pin conditioning
  // ----------------------------------------------------------------
  rx_sync_edge u_rx (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (rx_pin),
    .level (rx_lvl),
    .rise  (rx_rise),
    .fall  (rx_fall)
  );

  // address decode, used only for the error answer
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == uart_bwa_pkg::CTRL_OFS) || (a == uart_bwa_pkg::MODE_OFS) ||
             (a == uart_bwa_pkg::DIV_OFS)  || (a == uart_bwa_pkg::STAT_OFS) ||
             (a == uart_bwa_pkg::MASK_OFS) || (a == uart_bwa_pkg::STATE_OFS);
  endfunction : mapped

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr     = access & pwrite & ce;

  // 8-bit mode uses only the low byte of the divisor
  assign reload = ctrl_r[uart_bwa_pkg::WIDE_BIT] ? div_r
                                                 : {8'h00, div_r[7:0]};

  // eight bit periods measured, so divide by eight; period is div+1
  assign meas_div = meas_r[uart_bwa_pkg::ABD_SHIFT +: 16] - 16'h0001;

  // ----------------------------------------------------------------
  // baud generator: counts down, reloads at zero, parked in autobaud
  // ----------------------------------------------------------------
  always_comb
  begin
    gen_nxt  = gen_r;
    tick_nxt = 1'b0;
    if (abd_r != uart_bwa_pkg::AB_IDLE)
    begin
      // the counter belongs to the measurement now
      gen_nxt = reload;
    end
    else if (gen_r == 16'h0000)
    begin
      gen_nxt  = reload;
      tick_nxt = 1'b1;
    end
    else
      gen_nxt = gen_r - 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gen_r  <= uart_bwa_pkg::DIV_RST;
      tick_r <= 1'b0;
    end
    else if (ce)
    begin
      gen_r  <= gen_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign baud_tick = tick_r & ce;

  // ----------------------------------------------------------------
  // control: registers, wake monitor, autobaud, events, apb
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    sync_nxt  = sync_r;
    div_nxt   = div_r;
    mask_nxt  = mask_r;
    armed_nxt = armed_r;
    abd_nxt   = abd_r;
    falls_nxt = falls_r;
    meas_nxt  = meas_r;
    ev_set    = '0;
    rd_nxt    = rd_r;
    err_nxt   = 1'b0;

    // wake monitor only runs in async mode with its enable set
    if (ctrl_r[uart_bwa_pkg::WAKE_BIT] && !sync_r)
    begin
      if (rx_fall)
      begin
        ev_set[uart_bwa_pkg::EV_WAKE] = 1'b1;
        armed_nxt = 1'b1;
      end
      else if (armed_r && rx_rise)
      begin
        ctrl_nxt[uart_bwa_pkg::WAKE_BIT] = 1'b0;
        armed_nxt = 1'b0;
      end
    end
    else
      armed_nxt = 1'b0;

    // autobaud sequence
    unique case (abd_r)
      uart_bwa_pkg::AB_IDLE:
        if (ctrl_r[uart_bwa_pkg::ABD_BIT] && !sync_r)
          abd_nxt = uart_bwa_pkg::AB_WAIT;
      uart_bwa_pkg::AB_WAIT:
      begin
        // start bit of the sync character opens the window
        if (sync_r || !ctrl_r[uart_bwa_pkg::ABD_BIT])
          abd_nxt = uart_bwa_pkg::AB_IDLE;
        else if (rx_fall)
        begin
          abd_nxt   = uart_bwa_pkg::AB_MEAS;
          falls_nxt = 3'h1;
          meas_nxt  = MEAS_W'(1); // start cycle is the first clock of the span
        end
      end
      uart_bwa_pkg::AB_MEAS:
      begin
        meas_nxt = meas_r + 1'b1;
        if (sync_r || !ctrl_r[uart_bwa_pkg::ABD_BIT])
          abd_nxt = uart_bwa_pkg::AB_IDLE;
        else if (&meas_r)
        begin
          // line too slow or not a sync character: give up
          abd_nxt = uart_bwa_pkg::AB_IDLE;
          ctrl_nxt[uart_bwa_pkg::ABD_BIT] = 1'b0;
          ev_set[uart_bwa_pkg::EV_ABD_OVF] = 1'b1;
        end
        else if (rx_fall)
        begin
          falls_nxt = falls_r + 3'h1;
          if (falls_r == uart_bwa_pkg::ABD_FALLS - 3'h1)
          begin
            abd_nxt = uart_bwa_pkg::AB_IDLE;
            div_nxt = meas_div;
            ctrl_nxt[uart_bwa_pkg::ABD_BIT] = 1'b0;
            ev_set[uart_bwa_pkg::EV_ABD_OK] = 1'b1;
          end
        end
      end
    endcase

    // software writes win over a hardware self-clear in the same cycle
    if (wr)
    begin
      unique case (paddr)
        uart_bwa_pkg::CTRL_OFS:
        begin
          ctrl_nxt = pwdata[uart_bwa_pkg::CTRL_W-1:0];
          ctrl_nxt[uart_bwa_pkg::UNIMP_BIT] = 1'b0;
        end
        uart_bwa_pkg::MODE_OFS: sync_nxt = pwdata[uart_bwa_pkg::SYNC_BIT];
        uart_bwa_pkg::DIV_OFS:  div_nxt  = pwdata[15:0];
        uart_bwa_pkg::MASK_OFS: mask_nxt = pwdata[uart_bwa_pkg::EV_W-1:0];
        default:                ;
      endcase
    end

    // sticky events: set beats a write-one clear
    stat_nxt = stat_r | ev_set;
    if (wr && paddr == uart_bwa_pkg::STAT_OFS)
      stat_nxt = (stat_r & ~pwdata[uart_bwa_pkg::EV_W-1:0]) | ev_set;

    // read data captured in setup, answered in access
    if (setup)
    begin
      unique case (paddr)
        uart_bwa_pkg::CTRL_OFS:  rd_nxt = {28'h0000000, ctrl_r};
        uart_bwa_pkg::MODE_OFS:  rd_nxt = {31'h00000000, sync_r};
        uart_bwa_pkg::DIV_OFS:   rd_nxt = {16'h0000, div_r};
        uart_bwa_pkg::STAT_OFS:  rd_nxt = {29'h00000000, stat_r};
        uart_bwa_pkg::MASK_OFS:  rd_nxt = {29'h00000000, mask_r};
        uart_bwa_pkg::STATE_OFS: rd_nxt = {28'h0000000, armed_r, abd_r, rx_lvl};
        default:                 rd_nxt = 32'h00000000;
      endcase
      err_nxt = ~mapped(paddr);
    end
    else if (access)
      err_nxt = err_r; // error answer holds through a stalled access
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_r  <= uart_bwa_pkg::CTRL_RST;
      sync_r  <= uart_bwa_pkg::MODE_RST;
      div_r   <= uart_bwa_pkg::DIV_RST;
      stat_r  <= '0;
      mask_r  <= uart_bwa_pkg::MASK_RST;
      armed_r <= 1'b0;
      abd_r   <= uart_bwa_pkg::AB_IDLE;
      falls_r <= 3'h0;
      meas_r  <= '0;
      rd_r    <= 32'h00000000;
      err_r   <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_r  <= ctrl_nxt;
      sync_r  <= sync_nxt;
      div_r   <= div_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      armed_r <= armed_nxt;
      abd_r   <= abd_nxt;
      falls_r <= falls_nxt;
      meas_r  <= meas_nxt;
      rd_r    <= rd_nxt;
      err_r   <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bus answers and interrupt
  // ----------------------------------------------------------------
  // a frozen block cannot complete a transfer, so ready follows ce
  assign pready  = ce;
  assign prdata  = rd_r;
  assign pslverr = access & err_r;
  assign irq     = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_unimp_bit_zero: assert property (
    access && !pwrite && paddr == uart_bwa_pkg::CTRL_OFS
      |-> prdata[uart_bwa_pkg::UNIMP_BIT] == 1'b0)
    else $error("unimplemented control bit read nonzero");
  a_narrow_gen_byte: assert property (
    !ctrl_r[uart_bwa_pkg::WIDE_BIT] && ce && gen_r == 16'h0000
      |=> gen_r[15:8] == 8'h00)
    else $error("8-bit generator reloaded a high byte");
  a_wake_sets_event: assert property (
    ce && ctrl_r[uart_bwa_pkg::WAKE_BIT] && !sync_r && rx_fall
      |=> stat_r[uart_bwa_pkg::EV_WAKE] && armed_r)
    else $error("wake falling edge did not set the event");
  a_wake_self_clear: assert property (
    ce && armed_r && ctrl_r[uart_bwa_pkg::WAKE_BIT] && !sync_r && rx_rise
      && !rx_fall && !wr
      |=> !ctrl_r[uart_bwa_pkg::WAKE_BIT] && !armed_r)
    else $error("wake enable not cleared on rising edge");
  a_wake_off_idle: assert property (
    !ctrl_r[uart_bwa_pkg::WAKE_BIT] && ce |=> !armed_r)
    else $error("wake monitor armed while disabled");
  a_sync_no_wake: assert property (
    sync_r && ce && !stat_r[uart_bwa_pkg::EV_WAKE]
      |=> !stat_r[uart_bwa_pkg::EV_WAKE])
    else $error("wake event raised in synchronous mode");
  a_abd_starts: assert property (
    ce && abd_r == uart_bwa_pkg::AB_WAIT && ctrl_r[uart_bwa_pkg::ABD_BIT]
      && !sync_r && rx_fall
      |=> abd_r == uart_bwa_pkg::AB_MEAS && falls_r == 3'h1)
    else $error("autobaud did not start on start bit");
  a_abd_self_clear: assert property (
    ce && abd_r == uart_bwa_pkg::AB_MEAS && ctrl_r[uart_bwa_pkg::ABD_BIT]
      && !sync_r && !(&meas_r) && rx_fall && falls_r == 3'h4 && !wr
      |=> !ctrl_r[uart_bwa_pkg::ABD_BIT] && abd_r == uart_bwa_pkg::AB_IDLE
          && stat_r[uart_bwa_pkg::EV_ABD_OK])
    else $error("autobaud enable not cleared at completion");
  a_abd_loads_div: assert property (
    ce && abd_r == uart_bwa_pkg::AB_MEAS && ctrl_r[uart_bwa_pkg::ABD_BIT]
      && !sync_r && !(&meas_r) && rx_fall && falls_r == 3'h4 && !wr
      |=> div_r == $past(meas_div))
    else $error("measured divisor not loaded");
  c_wake_cycle:  cover property (armed_r ##[1:1000] !ctrl_r[uart_bwa_pkg::WAKE_BIT]);
  c_abd_done:    cover property ($rose(stat_r[uart_bwa_pkg::EV_ABD_OK]));
  c_abd_ovf:     cover property ($rose(stat_r[uart_bwa_pkg::EV_ABD_OVF]));
  c_irq_raised:  cover property ($rose(irq));

endmodule : uart_baud_wake_autobaud_ctrl

`default_nettype wire

// [uart_baud_wake_autobaud_ctrl_tb.sv]
// Purpose: self-checking bench of the baud control block
// Assumes: zero wait apb slave while ce is high
// Notes:   ce is tied high; stall behaviour is left unexercised
`timescale 1ns/1ps
`default_nettype none

module uart_baud_wake_autobaud_ctrl_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk     = 1'b0;  // 50 MHz
  logic        rst_n   = 1'b0;  // synchronous reset
  logic        psel    = 1'b0;  // apb select
  logic        penable = 1'b0;  // apb access phase
  logic        pwrite  = 1'b0;  // apb direction
  logic [7:0]  paddr   = 8'h00; // apb address
  logic [31:0] pwdata  = 32'h0; // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready;          // apb ready
  logic        pslverr;         // apb error
  logic        rx_pin;          // line from the model
  logic        baud_tick;       // generator pulse
  logic        irq;             // level interrupt
  logic        last_err;        // pslverr of last transfer
  logic [31:0] q;               // last read data
  int          n_fail  = 0;     // mismatches
  int          n_tests = 0;     // comparisons

  always #10 clk = ~clk;

  uart_baud_wake_autobaud_ctrl dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .baud_tick(baud_tick),
    .irq(irq)
  );

  rx_tx_model tx (.clk(clk), .line(rx_pin));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // a wait that ran out of its bound ends the run
  task automatic timeout(input string what);
    n_fail++;
    $display("[FAIL] %s expected done seen timeout", what);
    print_verdict();
  endtask : timeout

  task automatic check(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 50 && pready !== 1'b1; k++)
      @(posedge clk);
    if (k == 50)
      timeout("apb ready");
    q        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // clocks between the last two ticks; earlier gaps may use old divisor
  task automatic tick_gap(output int g);
    for (int j = 0; j < 3; j++)
    begin
      g = 1;
      @(posedge clk);
      while (baud_tick !== 1'b1 && g < 2000)
      begin
        @(posedge clk);
        g++;
      end
      if (g == 2000)
        timeout("baud tick");
    end
  endtask : tick_gap

  // low then high level on the line, 10 clocks each
  task automatic pulse();
    tx.drive(1'b0);
    repeat (10) @(posedge clk);
    tx.drive(1'b1);
    repeat (10) @(posedge clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(uart_bwa_pkg::CTRL_OFS);
    check("ctrl reset", q, 32'h0);
    rd(uart_bwa_pkg::DIV_OFS);
    check("div reset", q, 32'h1f);
    rd(uart_bwa_pkg::MASK_OFS);
    check("mask reset", q, 32'h0);
    rd(uart_bwa_pkg::MODE_OFS);
    check("mode reset", q, 32'h0);
    rd(uart_bwa_pkg::STAT_OFS);
    check("stat reset", q, 32'h0);
    // idle line reads as level one, autobaud idle, wake not armed
    rd(uart_bwa_pkg::STATE_OFS);
    check("state reset", q, 32'h1);
    rd(8'h18);
    check("unmapped data", q, 32'h0);
    check("unmapped err", {31'h0, last_err}, 32'h1);
  endtask : t_reset

  task automatic t_bit2();
    wr(uart_bwa_pkg::CTRL_OFS, 32'h0c);
    rd(uart_bwa_pkg::CTRL_OFS);
    check("ctrl bit2 set", q, 32'h08);
    wr(uart_bwa_pkg::CTRL_OFS, 32'h04);
    rd(uart_bwa_pkg::CTRL_OFS);
    check("ctrl bit2 only", q, 32'h0);
  endtask : t_bit2

  // divisor 0x0103: narrow counter sees only the low byte
  task automatic t_width();
    int g;
    wr(uart_bwa_pkg::DIV_OFS, 32'h0103);
    tick_gap(g);
    check("gap 8-bit", g, 32'd4);
    wr(uart_bwa_pkg::CTRL_OFS, 32'h08);
    tick_gap(g);
    check("gap 16-bit", g, 32'd260);
    wr(uart_bwa_pkg::CTRL_OFS, 32'h0);
  endtask : t_width

  task automatic t_wake();
    wr(uart_bwa_pkg::MASK_OFS, 32'h1);
    wr(uart_bwa_pkg::CTRL_OFS, 32'h2);
    tx.drive(1'b0);
    repeat (10) @(posedge clk);
    check("wake irq", {31'h0, irq}, 32'h1);
    // line held low: armed bit set, level bit low
    rd(uart_bwa_pkg::STATE_OFS);
    check("wake armed state", q, 32'h8);
    rd(uart_bwa_pkg::STAT_OFS);
    check("wake status", q, 32'h1);
    rd(uart_bwa_pkg::CTRL_OFS);
    check("wake still armed", q, 32'h2);
    tx.drive(1'b1);
    repeat (10) @(posedge clk);
    rd(uart_bwa_pkg::CTRL_OFS);
    check("wake self clear", q, 32'h0);
    wr(uart_bwa_pkg::STAT_OFS, 32'h1);
    rd(uart_bwa_pkg::STAT_OFS);
    check("status w1c", q, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask : t_wake

  task automatic t_off_sync();
    pulse();
    rd(uart_bwa_pkg::STAT_OFS);
    check("wake off status", q, 32'h0);
    wr(uart_bwa_pkg::MODE_OFS, 32'h1);
    wr(uart_bwa_pkg::CTRL_OFS, 32'h2);
    pulse();
    rd(uart_bwa_pkg::STAT_OFS);
    check("sync status", q, 32'h0);
    rd(uart_bwa_pkg::CTRL_OFS);
    check("sync ctrl kept", q, 32'h2);
    wr(uart_bwa_pkg::CTRL_OFS, 32'h0);
    wr(uart_bwa_pkg::MODE_OFS, 32'h0);
  endtask : t_off_sync

  // 40 clocks a bit: a period of 40 clocks is divisor 39
  task automatic t_abd();
    wr(uart_bwa_pkg::CTRL_OFS, 32'h1);
    tx.send(uart_bwa_pkg::SYNC_CHAR, 40);
    repeat (10) @(posedge clk);
    rd(uart_bwa_pkg::CTRL_OFS);
    check("abd self clear", q, 32'h0);
    rd(uart_bwa_pkg::STAT_OFS);
    check("abd done", q, 32'h2);
    rd(uart_bwa_pkg::DIV_OFS);
    check("abd divisor", q, 32'd39);
  endtask : t_abd

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bit2();
    t_width();
    t_wake();
    t_off_sync();
    t_abd();
    print_verdict();
  end
endmodule : uart_baud_wake_autobaud_ctrl_tb

`default_nettype wire

// [uart_bwa_pkg.sv]
// Purpose: shared constants and types of the baud control block
// Assumes: apb slave with 32-bit data, byte addresses
// Notes:   one source for offsets, field positions and reset values
package uart_bwa_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS  = 8'h00; // baud_control
  localparam logic [7:0] MODE_OFS  = 8'h04; // sync/async mode select
  localparam logic [7:0] DIV_OFS   = 8'h08; // baud divisor
  localparam logic [7:0] STAT_OFS  = 8'h0c; // sticky events, write one to clear
  localparam logic [7:0] MASK_OFS  = 8'h10; // event mask
  localparam logic [7:0] STATE_OFS = 8'h14; // live state, read only

  // ----------------------------------------------------------------
  // baud_control field positions
  // ----------------------------------------------------------------
  localparam int ABD_BIT    = 0; // autobaud_enable
  localparam int WAKE_BIT   = 1; // wake_monitor_enable
  localparam int UNIMP_BIT  = 2; // not implemented, reads zero
  localparam int WIDE_BIT   = 3; // wide_generator_select
  localparam int CTRL_W     = 4;
  localparam int SYNC_BIT   = 0; // mode register: 1 = synchronous

  // ----------------------------------------------------------------
  // event bits of status and mask
  // ----------------------------------------------------------------
  localparam int EV_WAKE    = 0; // wake falling edge seen
  localparam int EV_ABD_OK  = 1; // autobaud measurement finished
  localparam int EV_ABD_OVF = 2; // measurement ran out of range
  localparam int EV_W       = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic              MODE_RST = 1'h0;
  localparam logic [15:0]       DIV_RST  = 16'h001f;
  localparam logic [EV_W-1:0]   MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // sync character and measurement figures
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_CHAR  = 8'h55; // expected from the far end
  localparam logic [2:0] ABD_FALLS  = 3'h5;  // falling edges in one 55h frame
  localparam int         ABD_SHIFT  = 3;     // 5 falls span 8 bit periods

  typedef enum logic [1:0] {AB_IDLE, AB_WAIT, AB_MEAS} abd_state_t;

endpackage : uart_bwa_pkg
